/* File: shared/ms_prot_defines.vh */
// constants for the linear protection termination and adaptation block
`ifndef MS_PROT_DEFINES_VH
`define MS_PROT_DEFINES_VH

// ==========================================================
// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STATUS 8'h08
`define REG_IRQ_MASK 8'h0c
`define REG_APS_RX 8'h10

// ==========================================================
// control fields and reset value
`define CTRL_REPORT_EN 0
`define CTRL_PROT_SECTION 1
`define CTRL_RESET 2'h0

// ==========================================================
// status fields
`define STAT_SERVER_FAIL_CORRELATED 0
`define STAT_TSF 1
`define STAT_SSF 2
`define STAT_SSD 3

// ==========================================================
// interrupt fields and reset value
`define IRQ_APS_NEW 0
`define IRQ_TSF_RISE 1
`define IRQ_TSD_RISE 2
`define IRQ_WIDTH 3
`define IRQ_RESET 3'h0

// ==========================================================
// switching channel layout and filter
`define APS_WIDTH 13
`define APS_K2_BITS 5
`define APS_PERSIST 2'd3
`define APS_CNT_WIDTH 2

// ==========================================================
// frame positions of the two channel bytes
`define POS_WIDTH 16
`define K1_POS 16'h0010
`define K2_POS 16'h0011

`endif

/* File: hdl/frame_byte_counter.v */
// byte position counter of a framed byte stream
`timescale 1ns/1ps
module frame_byte_counter #(
  parameter PW = 16
) (
  input wire clk,
  input wire rstN,
  input wire frameStart,
  output wire [PW-1:0] pos
);
  reg [PW-1:0] cntR;

  // position of the current byte; saturates so a lost frame start never wraps into a channel slot
  assign pos = frameStart ? {PW{1'b0}} : ((&cntR) ? cntR : cntR + {{(PW-1){1'b0}}, 1'b1});

  // remember position of the last byte
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cntR <= {PW{1'b1}};
    end else begin
      cntR <= pos;
    end
  end
endmodule

/* File: hdl/aps_persist_filter.v */
// persistence filter: accepts a value seen in a run of identical frames
`timescale 1ns/1ps
module aps_persist_filter #(
  parameter W = 13,
  parameter CW = 2,
  parameter [CW-1:0] PERSIST = 2'd3
) (
  input wire clk,
  input wire rstN,
  input wire enable,
  input wire strobe,
  input wire [W-1:0] cand,
  output reg [W-1:0] accepted,
  output reg newPulse
);
  reg [W-1:0] lastR;
  reg [CW-1:0] cntR;
  reg [CW-1:0] cntNxt;

  // run length including this frame, held at the persistence figure
  always @* begin
    if (cand != lastR) begin
      cntNxt = {{(CW-1){1'b0}}, 1'b1};
    end else if (cntR == PERSIST) begin
      cntNxt = PERSIST;
    end else begin
      cntNxt = cntR + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // disabled instance holds nothing, so a later enable starts a fresh run
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      lastR <= {W{1'b0}};
      cntR <= {CW{1'b0}};
      accepted <= {W{1'b0}};
      newPulse <= 1'b0;
    end else if (!enable) begin
      lastR <= {W{1'b0}};
      cntR <= {CW{1'b0}};
      accepted <= {W{1'b0}};
      newPulse <= 1'b0;
    end else begin
      newPulse <= 1'b0;
      if (strobe) begin
        lastR <= cand;
        cntR <= cntNxt;
        if (cntNxt == PERSIST && cand != accepted) begin
          accepted <= cand;
          newPulse <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: hdl/ms_prot_term_adapt.v */
// linear protection sublayer trail termination and adaptation, source and sink
//
// Function
// - termination source forwards data, clock, frame start unchanged, no checks
// - termination sink forwards connection stream to access output, reports trail state
// - termination sink trail fail output follows incoming server signal fail
// - adaptation source inserts switching channel into the section data stream
// - adaptation sink recovers the sublayer data stream with clock and frame start
// - channel is thirteen bits: all of K1 then top five bits of K2
// - new channel value taken only after three identical consecutive frames
// - adaptation sink outputs the last accepted channel value
// - extraction and filtering run only in the protection section instance
`timescale 1ns/1ps
`include "ms_prot_defines.vh"
module ms_prot_term_adapt #(
  parameter PW = `POS_WIDTH,
  parameter [PW-1:0] K1POS = `K1_POS,
  parameter [PW-1:0] K2POS = `K2_POS
) (
  input wire core_clk,
  input wire reset_n,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire irq,
  input wire [7:0] srcAccessPointData,
  input wire srcAccessPointClock,
  input wire srcAccessPointFrameStart,
  output reg [7:0] srcConnectionData,
  output reg srcConnectionClock,
  output reg srcConnectionFrameStart,
  input wire [7:0] insConnectionData,
  input wire insConnectionClock,
  input wire insConnectionFrameStart,
  input wire [`APS_WIDTH-1:0] txProtSwitchChannel,
  output reg [7:0] insAccessPointData,
  output reg insAccessPointClock,
  output reg insAccessPointFrameStart,
  input wire [7:0] extAccessPointData,
  input wire extAccessPointClock,
  input wire extAccessPointFrameStart,
  input wire trailSignalFail,
  input wire trailSignalDegrade,
  output reg [7:0] extConnectionData,
  output reg extConnectionClock,
  output reg extConnectionFrameStart,
  output reg serverSignalFail,
  output reg serverSignalDegrade,
  output wire [`APS_WIDTH-1:0] protSwitchChannel,
  input wire [7:0] termConnectionData,
  input wire termConnectionClock,
  input wire termConnectionFrameStart,
  input wire termServerSignalFail,
  output reg [7:0] termAccessPointData,
  output reg termAccessPointClock,
  output reg termAccessPointFrameStart,
  output reg termTrailSignalFail,
  output reg serverFailReportedStatus
);

  // ==========================================================
  // reset release
  reg [1:0] rstSyncR;
  wire rstN;

  // asynchronous assert, release after two clean edges
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSyncR <= 2'b00;
    end else begin
      rstSyncR <= {rstSyncR[0], 1'b1};
    end
  end
  assign rstN = rstSyncR[1];

  // ==========================================================
  // register bus slave
  reg [1:0] ctrlR;
  reg [`IRQ_WIDTH-1:0] irqStatR;
  reg [`IRQ_WIDTH-1:0] irqMaskR;
  reg ackR;
  wire busReq;
  wire wrDone;
  wire [`IRQ_WIDTH-1:0] irqEvents;
  wire [3:0] statusBits;
  wire reportEnable;
  wire protSection;

  assign busReq = avs_read | avs_write;
  // one wait cycle per access, then the answer; keeps read data registered
  assign avs_waitrequest = busReq & ~ackR;
  assign wrDone = avs_write & ackR;
  assign reportEnable = ctrlR[`CTRL_REPORT_EN];
  assign protSection = ctrlR[`CTRL_PROT_SECTION];

  // acknowledge toggles so back to back requests each see one wait cycle
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      ackR <= 1'b0;
    end else begin
      ackR <= busReq & ~ackR;
    end
  end

  // read data loaded in the wait cycle, stable at the completing edge
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ackR) begin
      case (avs_address)
        `REG_CTRL: begin
          avs_readdata <= {30'h00000000, ctrlR};
        end
        `REG_STATUS: begin
          avs_readdata <= {28'h0000000, statusBits};
        end
        `REG_IRQ_STATUS: begin
          avs_readdata <= {29'h00000000, irqStatR};
        end
        `REG_IRQ_MASK: begin
          avs_readdata <= {29'h00000000, irqMaskR};
        end
        `REG_APS_RX: begin
          avs_readdata <= {19'h00000, protSwitchChannel};
        end
        default: begin
          avs_readdata <= 32'h00000000;
        end
      endcase
    end
  end

  // control and mask writes take effect on the completing edge
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      ctrlR <= `CTRL_RESET;
      irqMaskR <= `IRQ_RESET;
    end else if (wrDone && avs_byteenable[0]) begin
      if (avs_address == `REG_CTRL) begin
        ctrlR <= avs_writedata[1:0];
      end
      if (avs_address == `REG_IRQ_MASK) begin
        irqMaskR <= avs_writedata[`IRQ_WIDTH-1:0];
      end
    end
  end

  // sticky events, write one to clear; a new event in the clearing cycle survives
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      irqStatR <= `IRQ_RESET;
    end else if (wrDone && avs_byteenable[0] && avs_address == `REG_IRQ_STATUS) begin
      irqStatR <= (irqStatR & ~avs_writedata[`IRQ_WIDTH-1:0]) | irqEvents;
    end else begin
      irqStatR <= irqStatR | irqEvents;
    end
  end

  assign irq = |(irqStatR & irqMaskR);

  // ==========================================================
  // termination source: plain pass through
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      srcConnectionData <= 8'h00;
      srcConnectionClock <= 1'b0;
      srcConnectionFrameStart <= 1'b0;
    end else begin
      srcConnectionData <= srcAccessPointData;
      srcConnectionClock <= srcAccessPointClock;
      srcConnectionFrameStart <= srcAccessPointFrameStart;
    end
  end

  // ==========================================================
  // adaptation source: channel insertion
  wire [PW-1:0] insPos;

  frame_byte_counter #(
    .PW(PW)
  ) insCounter (
    .clk(core_clk),
    .rstN(rstN),
    .frameStart(insConnectionFrameStart),
    .pos(insPos)
  );

  // K1 takes the top eight channel bits, K2 the low five above its own three
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      insAccessPointData <= 8'h00;
      insAccessPointClock <= 1'b0;
      insAccessPointFrameStart <= 1'b0;
    end else begin
      if (insPos == K1POS) begin
        insAccessPointData <= txProtSwitchChannel[`APS_WIDTH-1:`APS_K2_BITS];
      end else if (insPos == K2POS) begin
        insAccessPointData <= {txProtSwitchChannel[`APS_K2_BITS-1:0], insConnectionData[2:0]};
      end else begin
        insAccessPointData <= insConnectionData;
      end
      insAccessPointClock <= insConnectionClock;
      insAccessPointFrameStart <= insConnectionFrameStart;
    end
  end

  // ==========================================================
  // adaptation sink: stream recovery, channel extraction, fail indications
  wire [PW-1:0] extPos;
  wire apsNew;
  reg [7:0] k1R;
  reg candStrobeR;
  reg [`APS_WIDTH-1:0] candR;
  reg tsfPrevR;
  reg tsdPrevR;

  frame_byte_counter #(
    .PW(PW)
  ) extCounter (
    .clk(core_clk),
    .rstN(rstN),
    .frameStart(extAccessPointFrameStart),
    .pos(extPos)
  );

  // the sublayer stream is the access stream delayed one cycle
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      extConnectionData <= 8'h00;
      extConnectionClock <= 1'b0;
      extConnectionFrameStart <= 1'b0;
      serverSignalFail <= 1'b0;
      serverSignalDegrade <= 1'b0;
    end else begin
      extConnectionData <= extAccessPointData;
      extConnectionClock <= extAccessPointClock;
      extConnectionFrameStart <= extAccessPointFrameStart;
      serverSignalFail <= trailSignalFail;
      serverSignalDegrade <= trailSignalDegrade;
    end
  end

  // one candidate per frame, offered once its K2 byte has passed
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      k1R <= 8'h00;
      candR <= {`APS_WIDTH{1'b0}};
      candStrobeR <= 1'b0;
    end else begin
      candStrobeR <= 1'b0;
      if (protSection && extPos == K1POS) begin
        k1R <= extAccessPointData;
      end
      if (protSection && extPos == K2POS) begin
        candR <= {k1R, extAccessPointData[7:8-`APS_K2_BITS]};
        candStrobeR <= 1'b1;
      end
    end
  end

  // working section instances hold the channel output at zero
  aps_persist_filter #(
    .W(`APS_WIDTH),
    .CW(`APS_CNT_WIDTH),
    .PERSIST(`APS_PERSIST)
  ) apsFilter (
    .clk(core_clk),
    .rstN(rstN),
    .enable(protSection),
    .strobe(candStrobeR),
    .cand(candR),
    .accepted(protSwitchChannel),
    .newPulse(apsNew)
  );

  // edge detectors for the fail and degrade events
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      tsfPrevR <= 1'b0;
      tsdPrevR <= 1'b0;
    end else begin
      tsfPrevR <= trailSignalFail;
      tsdPrevR <= trailSignalDegrade;
    end
  end

  assign irqEvents = {trailSignalDegrade & ~tsdPrevR, trailSignalFail & ~tsfPrevR, apsNew};

  // ==========================================================
  // termination sink: pass through and trail state report
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      termAccessPointData <= 8'h00;
      termAccessPointClock <= 1'b0;
      termAccessPointFrameStart <= 1'b0;
      termTrailSignalFail <= 1'b0;
      serverFailReportedStatus <= 1'b0;
    end else begin
      termAccessPointData <= termConnectionData;
      termAccessPointClock <= termConnectionClock;
      termAccessPointFrameStart <= termConnectionFrameStart;
      termTrailSignalFail <= termServerSignalFail;
      serverFailReportedStatus <= termServerSignalFail & reportEnable;
    end
  end

  assign statusBits = {serverSignalDegrade, serverSignalFail, termTrailSignalFail, serverFailReportedStatus};

endmodule

/* File: verification/ms_prot_term_adapt_asserts.sv */
// assertion checker for the protection termination and adaptation block
`timescale 1ns/1ps
`include "ms_prot_defines.vh"
module ms_prot_asserts #(
  parameter PW = 16,
  parameter [PW-1:0] K1POS = 16,
  parameter [PW-1:0] K2POS = 17
) (
  input wire core_clk,
  input wire reset_n,
  input wire srcAccessPointClock,
  input wire srcAccessPointFrameStart,
  input wire srcConnectionClock,
  input wire srcConnectionFrameStart,
  input wire insConnectionClock,
  input wire insAccessPointClock,
  input wire insAccessPointFrameStart,
  input wire extAccessPointClock,
  input wire extConnectionClock,
  input wire extConnectionFrameStart,
  input wire termConnectionClock,
  input wire termConnectionFrameStart,
  input wire termAccessPointClock,
  input wire termAccessPointFrameStart,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire [7:0] srcAccessPointData,
  input wire [7:0] srcConnectionData,
  input wire [7:0] insConnectionData,
  input wire insConnectionFrameStart,
  input wire [`APS_WIDTH-1:0] txProtSwitchChannel,
  input wire [7:0] insAccessPointData,
  input wire [7:0] extAccessPointData,
  input wire extAccessPointFrameStart,
  input wire trailSignalFail,
  input wire trailSignalDegrade,
  input wire [7:0] extConnectionData,
  input wire serverSignalFail,
  input wire serverSignalDegrade,
  input wire [`APS_WIDTH-1:0] protSwitchChannel,
  input wire [7:0] termConnectionData,
  input wire termServerSignalFail,
  input wire [7:0] termAccessPointData,
  input wire termTrailSignalFail,
  input wire serverFailReportedStatus
);
  // ==========================================
  // helper logic
  // waits out the two-flop release plus one edge so $past never sees reset values
  reg [2:0] rstSeen_r;
  reg [PW-1:0] insPos_r;
  reg [PW-1:0] extPos_r;
  wire [PW-1:0] insCur = insConnectionFrameStart ? {PW{1'b0}} : insPos_r;
  wire [PW-1:0] extCur = extAccessPointFrameStart ? {PW{1'b0}} : extPos_r;
  wire [7:0] k1Exp = txProtSwitchChannel[12:5];
  wire [7:0] k2Exp = {txProtSwitchChannel[4:0], insConnectionData[2:0]};
  wire extK2 = (extCur == K2POS);
  // byte positions, saturating like the block's own counter
  // positions stay frozen until the block's two-flop reset release is over, or they run ahead of it
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSeen_r <= 3'h0;
      insPos_r <= {PW{1'b1}};
      extPos_r <= {PW{1'b1}};
    end else begin
      rstSeen_r <= {rstSeen_r[1:0], 1'b1};
      if (rstSeen_r[1]) begin
        insPos_r <= (&insCur) ? insCur : insCur + 1'b1;
        extPos_r <= (&extCur) ? extCur : extCur + 1'b1;
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSeen_r[2]);
  // ==========================================
  // properties
  sequence k1Slot;
    insAccessPointData == $past(k1Exp);
  endsequence
  sequence k2Slot;
    insAccessPointData == $past(k2Exp);
  endsequence
  a_src_forward: assert property ({srcConnectionData, srcConnectionClock, srcConnectionFrameStart} ==
    $past({srcAccessPointData, srcAccessPointClock, srcAccessPointFrameStart}))
    else $error("source termination altered data");
  a_term_forward: assert property ({termAccessPointData, termAccessPointClock, termAccessPointFrameStart} ==
    $past({termConnectionData, termConnectionClock, termConnectionFrameStart}))
    else $error("sink termination altered data");
  a_trail_fail: assert property (termTrailSignalFail == $past(termServerSignalFail))
    else $error("trail fail does not follow server fail");
  a_report_gate: assert property (serverFailReportedStatus |-> $past(termServerSignalFail))
    else $error("reported status without server fail");
  a_ins_chan: assert property (insCur == K1POS |=> k1Slot ##1 k2Slot)
    else $error("channel bytes not inserted");
  a_ins_other: assert property (insCur != K1POS && insCur != K2POS |=> insAccessPointData == $past(insConnectionData))
    else $error("non channel byte altered");
  a_ins_timing: assert property ({insAccessPointClock, insAccessPointFrameStart} ==
    $past({insConnectionClock, insConnectionFrameStart}))
    else $error("source adaptation clock or frame start not forwarded");
  a_ext_forward: assert property ({extConnectionData, extConnectionClock, extConnectionFrameStart} ==
    $past({extAccessPointData, extAccessPointClock, extAccessPointFrameStart}))
    else $error("sink adaptation altered data");
  a_fail_follow: assert property (serverSignalFail == $past(trailSignalFail) && serverSignalDegrade == $past(trailSignalDegrade))
    else $error("fail or degrade not forwarded");
  a_aps_update: assert property ($changed(protSwitchChannel) && protSwitchChannel != 0 |-> $past(extK2, 2))
    else $error("channel changed off the frame update slot");
  a_bus_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
endmodule

bind ms_prot_term_adapt ms_prot_asserts #(.PW(PW), .K1POS(K1POS), .K2POS(K2POS)) chkInst (.*);

/* File: verification/frame_source.sv */
// far-end frame source feeding the stream inputs of the block
`timescale 1ns/1ps
`include "ms_prot_defines.vh"
module frame_source #(
  parameter FRAME_LEN = 24
) (
  input wire clk,
  input wire run,
  input wire [`APS_WIDTH-1:0] apsValue,
  output reg [7:0] data,
  output reg lineClock,
  output reg frameStart
);
  reg [15:0] pos_r;
  reg [7:0] frame_r;
  // ==========================================
  // byte counter, one byte per cycle, frame start on byte zero
  always @(posedge clk) begin
    if (!run) begin
      pos_r <= 16'h0;
      frame_r <= 8'h00;
    end else if (pos_r == FRAME_LEN - 1) begin
      pos_r <= 16'h0;
      frame_r <= frame_r + 8'h01;
    end else begin
      pos_r <= pos_r + 16'h1;
    end
  end
  // low bits of the K2 byte vary so the source must keep them
  always @* begin
    frameStart = run && (pos_r == 16'h0);
    lineClock = pos_r[0];
    data = {pos_r[3:0], frame_r[3:0]};
    if (pos_r == `K1_POS) data = apsValue[12:5];
    if (pos_r == `K2_POS) data = {apsValue[4:0], frame_r[2:0]};
  end
endmodule

/* File: verification/testbench.sv */
// register and stream tests of the protection termination and adaptation block
`timescale 1ns/1ps
`include "ms_prot_defines.vh"
module testbench;
  logic core_clk = 1'b0, reset_n = 1'b0, run = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [`APS_WIDTH-1:0] aps = 13'h0, txProtSwitchChannel = 13'h0b3c;
  logic trailSignalFail = 1'b0, trailSignalDegrade = 1'b0, termServerSignalFail = 1'b0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, irq, pClk, pFs;
  wire [7:0] pData, srcConnectionData, insAccessPointData, extConnectionData, termAccessPointData;
  wire srcConnectionClock, srcConnectionFrameStart, insAccessPointClock, insAccessPointFrameStart;
  wire extConnectionClock, extConnectionFrameStart, serverSignalFail, serverSignalDegrade;
  wire termAccessPointClock, termAccessPointFrameStart, termTrailSignalFail, serverFailReportedStatus;
  wire [`APS_WIDTH-1:0] protSwitchChannel;
  int errors = 0, num_checks = 0;
  logic [31:0] q;
  always #2 core_clk = ~core_clk;
  frame_source far (.clk(core_clk), .run(run), .apsValue(aps), .data(pData), .lineClock(pClk), .frameStart(pFs));
  ms_prot_term_adapt dut (.*,
    .srcAccessPointData(pData), .srcAccessPointClock(pClk), .srcAccessPointFrameStart(pFs),
    .insConnectionData(pData), .insConnectionClock(pClk), .insConnectionFrameStart(pFs),
    .extAccessPointData(pData), .extAccessPointClock(pClk), .extAccessPointFrameStart(pFs),
    .termConnectionData(pData), .termConnectionClock(pClk), .termConnectionFrameStart(pFs));
  // ==========================================
  // shared tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    // a bus answer that never comes counts against the run
    if (avs_waitrequest !== 1'b0) errors++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task regChk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task waitFrames(input int n);
    repeat (n) @(posedge core_clk iff pFs === 1'b1);
  endtask
  task test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hang guard, well beyond the dozen frames, a few hundred cycles, the tests need
  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    test_done;
  end
  // ==========================================
  // tests
  initial begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    run <= 1'b1;
    repeat (3) @(posedge core_clk);
    regChk(`REG_CTRL, 32'h0);
    regChk(`REG_IRQ_STATUS, 32'h0);
    bus(1'b1, 8'h14, 32'h7);
    regChk(8'h14, 32'h0);
    bus(1'b1, `REG_IRQ_MASK, 32'h7);
    regChk(`REG_IRQ_MASK, 32'h7);
    $display("test registers done");
    bus(1'b1, `REG_CTRL, 32'h2);
    waitFrames(1);
    aps <= 13'h1a5b;
    waitFrames(3);
    chk(protSwitchChannel, 32'h1a5b);
    regChk(`REG_APS_RX, 32'h1a5b);
    regChk(`REG_IRQ_STATUS, 32'h1);
    chk(irq, 32'h1);
    bus(1'b1, `REG_IRQ_STATUS, 32'h1);
    regChk(`REG_IRQ_STATUS, 32'h0);
    chk(irq, 32'h0);
    waitFrames(1);
    aps <= 13'h0421;
    txProtSwitchChannel <= 13'h14c3;
    waitFrames(2);
    aps <= 13'h1a5b;
    waitFrames(2);
    chk(protSwitchChannel, 32'h1a5b);
    aps <= 13'h0421;
    waitFrames(3);
    chk(protSwitchChannel, 32'h0421);
    bus(1'b1, `REG_IRQ_MASK, 32'h0);
    chk(irq, 32'h0);
    regChk(`REG_IRQ_STATUS, 32'h1);
    bus(1'b1, `REG_CTRL, 32'h0);
    repeat (2) @(posedge core_clk);
    chk(protSwitchChannel, 32'h0);
    $display("test channel done");
    trailSignalFail <= 1'b1;
    trailSignalDegrade <= 1'b1;
    termServerSignalFail <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk({serverSignalFail, serverSignalDegrade, termTrailSignalFail, serverFailReportedStatus}, 32'he);
    regChk(`REG_STATUS, 32'he);
    regChk(`REG_IRQ_STATUS, 32'h7);
    bus(1'b1, `REG_CTRL, 32'h1);
    regChk(`REG_STATUS, 32'hf);
    termServerSignalFail <= 1'b0;
    trailSignalFail <= 1'b0;
    repeat (2) @(posedge core_clk);
    regChk(`REG_STATUS, 32'h8);
    $display("test fail indications done");
    test_done;
  end
endmodule
